// ---- floppy_port.sv ----
// Purpose: Drive-side control and data port toward up to four floppy drives.
// Assumes: Drive pins are asynchronous and pass two flip-flops before use.
// Notes: Sector framing and data separation stay with the controller core.
// Operation
// - Four drive selects, one drive each
// - Motor on; mode 0 waits 40 ns
// - Mode nonzero waits one second before access
// - Motor off after three idle seconds
// - Direction high outward, low inward before stepping
// - One step pulse per cylinder travelled
// - Step period from stepping rate setting
// - Restore step period at least 8 us
// - Write data only while write gate asserted
// - Write gate held for whole write
// - Sample outermost-cylinder input before each step
// - Side select chooses disc surface
`timescale 1ns/1ps
module floppy_port
   import floppy_port_pkg::*;
#(
   parameter int MOTOR_SLOW_CYCLES = MOTOR_SLOW_CYC,
   parameter int MOTOR_IDLE_CYCLES = MOTOR_IDLE_CYC
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic srst,
   // Controller side: drive and side choice.
   input wire logic [1:0] drive_num,
   input wire logic side_sel,
   input wire logic motor_on_mode_option,
   input wire logic access_req,
   output logic access_ready,
   // Controller side: seek requests.
   input wire logic seek_start,
   input wire seek_kind_t seek_kind,
   input wire logic seek_outward,
   input wire logic [15:0] seek_count,
   input wire logic [RATE_W-1:0] step_rate,
   output logic seek_busy,
   output logic seek_at_outer,
   // Controller side: write stream.
   input wire logic write_req,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic wr_bit,
   output logic write_protect_err,
   // Controller side: read stream and drive status.
   output logic rd_bit,
   output logic index_seen,
   output logic write_protected,
   // Drive pins.
   output logic [NUM_DRIVES-1:0] drive_sel,
   output logic motor_on,
   output logic head_dir,
   output logic step,
   output logic write_data,
   output logic write_gate,
   output logic side_select,
   input wire logic index_in,
   input wire logic outer_cyl_in,
   input wire logic write_protect_in,
   input wire logic read_data_in
);

   // Elaboration check: a count below one cycle would leave the motor timing undefined.
   if (MOTOR_SLOW_CYCLES < 1 || MOTOR_IDLE_CYCLES < 1) begin
      $error("Motor timing counts must be at least one cycle.");
   end

   // Two-stage synchronisers for the four drive inputs.
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic index_prev_reg;

   // Motor state and counters.
   logic [31:0] spin_cnt_reg;
   logic [31:0] idle_cnt_reg;
   logic spun_reg;

   // Seek engine state.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_PULSE,
      ST_GAP
   } step_state_t;
   step_state_t st_reg;
   logic [15:0] left_reg;
   logic [31:0] tmr_reg;
   logic [31:0] period_reg;
   logic restore_reg;

   // Buffered write stream.
   logic buf_valid;
   logic buf_data;
   logic gate_ok;

   // Step period in cycles from the rate setting, clamped for restores.
   function automatic logic [31:0] step_period(input logic [RATE_W-1:0] rate, input logic is_restore);
      logic [31:0] p;
      p = 32'(rate) * 32'(RATE_UNIT_CYC);
      if (p < 32'(STEP_PULSE_CYC + 1)) begin
         p = 32'(STEP_PULSE_CYC + 1);
      end
      if (is_restore && p < 32'(RESTORE_MIN_CYC)) begin
         p = 32'(RESTORE_MIN_CYC);
      end
      step_period = p;
   endfunction

   // Synchronise index, outer cylinder, write protect and read data.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
         index_prev_reg <= 1'b0;
      end else begin
         sync1_reg <= {read_data_in, write_protect_in, outer_cyl_in, index_in};
         sync2_reg <= sync1_reg;
         index_prev_reg <= sync2_reg[0];
      end
   end

   // Index edge: the drive is trusted to pulse once per turn.
   assign index_seen = sync2_reg[0] && !index_prev_reg;
   assign write_protected = sync2_reg[2];
   assign seek_at_outer = sync2_reg[1];

   // Read data goes to the core raw; the core separates clock from data.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_bit <= 1'b0;
      end else begin
         rd_bit <= sync2_reg[3];
      end
   end

   // Drive and side selects follow the core's choice, one-hot.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         drive_sel <= '0;
         side_select <= 1'b0;
      end else begin
         drive_sel <= NUM_DRIVES'(1) << drive_num;
         side_select <= side_sel;
      end
   end

   // Motor: any access restarts the idle count; idle expiry stops the motor.
   // A mode change during spin-up applies to the wait in progress; once spun, only to the next spin-up.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         motor_on <= 1'b0;
         spin_cnt_reg <= '0;
         idle_cnt_reg <= '0;
         spun_reg <= 1'b0;
      end else if (access_req || write_req || seek_start) begin
         motor_on <= 1'b1;
         idle_cnt_reg <= '0;
         if (!motor_on) begin
            spin_cnt_reg <= '0;
            spun_reg <= 1'b0;
         end else if (!spun_reg) begin
            spin_cnt_reg <= spin_cnt_reg + 32'h1;
            spun_reg <= (spin_cnt_reg + 32'h1) >= (motor_on_mode_option ?
                        32'(MOTOR_SLOW_CYCLES) : 32'(MOTOR_FAST_CYC));
         end
      end else if (motor_on) begin
         if (idle_cnt_reg + 32'h1 >= 32'(MOTOR_IDLE_CYCLES) && st_reg == ST_IDLE) begin
            motor_on <= 1'b0;
            spun_reg <= 1'b0;
         end else begin
            idle_cnt_reg <= idle_cnt_reg + 32'h1;
         end
         if (!spun_reg) begin
            spin_cnt_reg <= spin_cnt_reg + 32'h1;
            spun_reg <= (spin_cnt_reg + 32'h1) >= (motor_on_mode_option ?
                        32'(MOTOR_SLOW_CYCLES) : 32'(MOTOR_FAST_CYC));
         end
      end
   end

   // Reads and writes wait until the spin-up time has passed.
   assign access_ready = motor_on && spun_reg;

   // Step engine: set direction, sample outer cylinder, pulse, then wait out the period.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_reg <= ST_IDLE;
         left_reg <= '0;
         tmr_reg <= '0;
         period_reg <= '0;
         restore_reg <= 1'b0;
         head_dir <= DIR_IN;
         step <= 1'b0;
      end else begin
         case (st_reg)
            ST_IDLE: begin
               step <= 1'b0;
               if (seek_start) begin
                  restore_reg <= (seek_kind == SEEK_RESTORE) || (seek_kind == SEEK_AUTO_RESTORE);
                  // Restores always move outward, toward the outermost cylinder.
                  head_dir <= (seek_outward || seek_kind == SEEK_RESTORE || seek_kind == SEEK_AUTO_RESTORE) ?
                              DIR_OUT : DIR_IN;
                  period_reg <= step_period(step_rate, (seek_kind == SEEK_RESTORE) ||
                                (seek_kind == SEEK_AUTO_RESTORE));
                  left_reg <= seek_count;
                  st_reg <= (seek_count == 16'h0 && seek_kind != SEEK_RESTORE &&
                             seek_kind != SEEK_AUTO_RESTORE) ? ST_IDLE : ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               // Outward motion stops at the outermost cylinder; a restore ends there.
               if ((head_dir == DIR_OUT && sync2_reg[1]) || (!restore_reg && left_reg == 16'h0)) begin
                  st_reg <= ST_IDLE;
               end else begin
                  step <= 1'b1;
                  tmr_reg <= '0;
                  st_reg <= ST_PULSE;
               end
            end
            ST_PULSE: begin
               tmr_reg <= tmr_reg + 32'h1;
               if (tmr_reg + 32'h1 >= 32'(STEP_PULSE_CYC)) begin
                  step <= 1'b0;
                  if (!restore_reg) begin
                     left_reg <= left_reg - 16'h1;
                  end
                  st_reg <= ST_GAP;
               end
            end
            ST_GAP: begin
               tmr_reg <= tmr_reg + 32'h1;
               // The sample state spends one cycle of the period, so the gap ends a cycle sooner.
               if (tmr_reg + 32'h2 >= period_reg) begin
                  st_reg <= ST_SAMPLE;
               end
            end
            default: begin
               st_reg <= ST_IDLE;
               step <= 1'b0;
            end
         endcase
      end
   end

   assign seek_busy = (st_reg != ST_IDLE);

   // Write gating: refused while the disc is protected.
   assign gate_ok = write_req && access_ready && !sync2_reg[2];

   // Protect error, set when a write is asked of a protected disc and held until write_req drops.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         write_protect_err <= 1'b0;
      end else if (write_req && sync2_reg[2]) begin
         write_protect_err <= 1'b1;
      end else if (!write_req) begin
         write_protect_err <= 1'b0;
      end
   end

   // Two-entry buffer so a stalled core never loses a bit.
   word_buffer #(
      .WIDTH(1)
   ) u_wbuf (
      .sys_clk(sys_clk),
      .srst(srst),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data(wr_bit),
      .out_valid(buf_valid),
      .out_ready(gate_ok),
      .out_data(buf_data)
   );

   // Gate held throughout the write; data is forced low when the gate is off.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         write_gate <= 1'b0;
         write_data <= 1'b0;
      end else begin
         write_gate <= gate_ok;
         write_data <= gate_ok && buf_valid && buf_data;
      end
   end

endmodule

// ---- floppy_port_pkg.sv ----
// Purpose: Shared constants and types for the floppy drive control port.
// Assumes: A single 100 MHz system clock.
// Notes: Long timing counts are overridable in the top module.
package floppy_port_pkg;

   // System clock period in nanoseconds.
   localparam int CLK_PERIOD_NS = 10;
   // Settle time after motor on when the motor-on mode option is 0.
   localparam int MOTOR_FAST_NS = 40;
   localparam int MOTOR_FAST_CYC = (MOTOR_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Spin-up wait in milliseconds when the motor-on mode option is not 0.
   localparam int MOTOR_SLOW_MS = 1000;
   localparam int MOTOR_SLOW_CYC = MOTOR_SLOW_MS * (1000000 / CLK_PERIOD_NS);
   // Idle time before the motor turns itself off, in milliseconds.
   localparam int MOTOR_IDLE_MS = 3000;
   localparam int MOTOR_IDLE_CYC = MOTOR_IDLE_MS * (1000000 / CLK_PERIOD_NS);
   // Least step period during restore, in nanoseconds.
   localparam int RESTORE_MIN_NS = 8000;
   localparam int RESTORE_MIN_CYC = (RESTORE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Width of the step pulse in cycles.
   localparam int STEP_PULSE_CYC = 100;
   // Step rate field width; the rate is in units of RATE_UNIT_CYC cycles.
   localparam int RATE_W = 8;
   localparam int RATE_UNIT_CYC = 100;
   // Head direction levels.
   localparam logic DIR_OUT = 1'b1;
   localparam logic DIR_IN = 1'b0;
   // Number of drives served.
   localparam int NUM_DRIVES = 4;

   // Seek request kinds.
   typedef enum logic [1:0] {
      SEEK_IMPLIED,
      SEEK_EXPLICIT,
      SEEK_RESTORE,
      SEEK_AUTO_RESTORE
   } seek_kind_t;

endpackage

// ---- word_buffer.sv ----
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Same clock on both sides.
// Notes: Read data come from a register; full ready is honest.
`timescale 1ns/1ps
module word_buffer #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic srst,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   // Two storage slots with a one-bit pointer each.
   logic [WIDTH-1:0] mem_reg [0:1];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] count_reg;
   logic push;
   logic pop;

   assign in_ready = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage write.
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and fill count.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   // Registered head word; it follows the slot the read pointer names.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         out_data <= '0;
      end else if (pop) begin
         out_data <= (count_reg == 2'h2) ? mem_reg[~rd_ptr_reg] : in_data;
      end else if (count_reg == 2'h0 && push) begin
         out_data <= in_data;
      end
   end

endmodule

// ---- floppy_port_asserts.sv ----
// Purpose: Concurrent checks on the floppy port pins.
// Assumes: One clock; srst is synchronous.
// Notes: Counters stand in for the long waits.
`timescale 1ns/1ps
module floppy_port_asserts
   import floppy_port_pkg::*;
#(
   parameter int MOTOR_SLOW_CYCLES = 50,
   parameter int MOTOR_IDLE_CYCLES = 200
) (
   // Clock, reset and requests.
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [1:0] drive_num,
   input wire logic motor_on_mode_option,
   input wire logic access_req,
   input wire logic write_req,
   input wire logic seek_start,
   input wire seek_kind_t seek_kind,
   input wire logic [RATE_W-1:0] step_rate,
   // Answers and drive pins.
   input wire logic seek_busy,
   input wire logic access_ready,
   input wire logic write_protected,
   input wire logic write_protect_err,
   input wire logic [NUM_DRIVES-1:0] drive_sel,
   input wire logic motor_on,
   input wire logic head_dir,
   input wire logic step,
   input wire logic write_data,
   input wire logic write_gate
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic take; // A seek is accepted this cycle.
   logic seen_reg; // A step has risen in this seek.
   logic restore_reg; // The seek in hand is a restore.
   logic [RATE_W-1:0] rate_reg; // Rate of the seek in hand.
   logic [15:0] gap_reg; // Cycles since the last step rise.
   logic [15:0] high_reg; // Cycles step has stood high.
   logic [31:0] on_reg; // Cycles the motor has run.
   logic [31:0] idle_reg; // Quiet cycles; a seek counts as activity.
   assign take = seek_start && !seek_busy;
   // Step spacing, restarted by each accepted seek.
   always_ff @(posedge sys_clk) begin
      if (srst || take) begin
         gap_reg <= 16'h0000;
         seen_reg <= 1'b0;
      end else if ($rose(step)) begin
         gap_reg <= 16'h0001;
         seen_reg <= 1'b1;
      end else if (gap_reg != 16'hFFFF) begin
         gap_reg <= gap_reg + 16'h0001;
      end
   end
   // Kind and rate of the accepted seek.
   always_ff @(posedge sys_clk) begin
      if (take) begin
         restore_reg <= seek_kind[1];
         rate_reg <= step_rate;
      end
   end
   // Pulse width and motor timing counters.
   always_ff @(posedge sys_clk) begin
      high_reg <= (srst || !step) ? 16'h0000 : high_reg + 16'h0001;
      on_reg <= (srst || !motor_on) ? 32'h0 : on_reg + 32'h1;
      idle_reg <= (srst || access_req || write_req || seek_busy) ? 32'h0 : idle_reg + 32'h1;
   end
   sequence s_next_step;
      $rose(step) && seen_reg;
   endsequence
   sequence s_refused;
      (write_req && write_protected) [*2];
   endsequence
   sequence s_writing;
      (write_req && access_ready && !write_protected) [*2];
   endsequence
   AST_SEL_ONEHOT: assert property (!$past(srst) |-> drive_sel == 4'h1 << $past(drive_num))
      else $error("drive select wrong");
   AST_SPINUP: assert property (access_ready && motor_on_mode_option |-> on_reg >= MOTOR_SLOW_CYCLES - 1)
      else $error("ready before spin-up");
   AST_IDLE_OFF: assert property (idle_reg >= MOTOR_IDLE_CYCLES + 4 |-> !motor_on)
      else $error("motor left on");
   AST_DIR_HOLD: assert property (step |-> $stable(head_dir))
      else $error("direction moved in step");
   AST_STEP_WIDTH: assert property ($fell(step) |-> high_reg == STEP_PULSE_CYC)
      else $error("step width wrong");
   AST_STEP_RATE: assert property (s_next_step ##0 (!restore_reg && rate_reg >= 8'h02) |->
      gap_reg == rate_reg * RATE_UNIT_CYC)
      else $error("step period wrong");
   AST_RESTORE_GAP: assert property (s_next_step ##0 restore_reg |-> gap_reg >= RESTORE_MIN_CYC)
      else $error("restore step too fast");
   AST_DATA_GATED: assert property (!write_gate |-> !write_data)
      else $error("data without gate");
   AST_WRITE_HOLD: assert property (s_writing |-> write_gate)
      else $error("gate dropped in write");
   AST_PROT_REFUSE: assert property (s_refused |-> !write_gate && write_protect_err)
      else $error("protected write not refused");
endmodule
bind floppy_port floppy_port_asserts #(
   .MOTOR_SLOW_CYCLES(MOTOR_SLOW_CYCLES),
   .MOTOR_IDLE_CYCLES(MOTOR_IDLE_CYCLES)
) floppy_port_asserts_inst (
   .sys_clk, .srst, .drive_num, .motor_on_mode_option, .access_req, .write_req,
   .seek_start, .seek_kind, .step_rate, .seek_busy, .access_ready, .write_protected,
   .write_protect_err, .drive_sel, .motor_on, .head_dir, .step, .write_data, .write_gate
);

// ---- floppy_drive_model.sv ----
// Purpose: Behavioural floppy drive facing the port.
// Assumes: One drive answers whichever select is high.
// Notes: Read data toggles so a stale bit never looks valid.
`timescale 1ns/1ps
module floppy_drive_model
   import floppy_port_pkg::*;
#(
   parameter int START_CYL = 3
) (
   // Clock and pins.
   input wire logic sys_clk,
   input wire logic [NUM_DRIVES-1:0] drive_sel,
   input wire logic step,
   input wire logic head_dir,
   input wire logic protect_ctl,
   output logic index_in,
   output logic outer_cyl_in,
   output logic write_protect_in,
   output logic read_data_in,
   output int cyl
);
   int rev_cnt = 0; // Cycles into the revolution.
   logic step_d = 1'b0; // Step one cycle back.
   initial cyl = START_CYL;
   initial read_data_in = 1'b0;
   // Heads move one cylinder per step rise and stop at the outermost.
   always @(posedge sys_clk) begin
      rev_cnt <= (rev_cnt == 999) ? 0 : rev_cnt + 1;
      step_d <= step;
      if (step && !step_d) begin
         cyl <= (head_dir == DIR_OUT) ? ((cyl > 0) ? cyl - 1 : 0) : cyl + 1;
      end
      read_data_in <= ~read_data_in;
   end
   assign index_in = (rev_cnt < 10) && (drive_sel != 4'h0);
   assign outer_cyl_in = (cyl == 0);
   assign write_protect_in = protect_ctl;
endmodule

// ---- floppy_port_bench.sv ----
// Purpose: Self-checking bench for the floppy port.
// Assumes: Short motor counts set through parameters.
// Notes: Each scenario is a task that judges its own result.
`timescale 1ns/1ps
module floppy_port_bench import floppy_port_pkg::*;;
   localparam int SLOW = 50; // Short spin-up keeps the run brief.
   localparam int IDLE = 200; // Short idle time before motor off.
   logic sys_clk = 1'b0, srst = 1'b1, side_sel = 1'b0, motor_on_mode_option = 1'b0;
   logic access_req = 1'b0, seek_start = 1'b0, seek_outward = 1'b0, write_req = 1'b0;
   logic wr_valid = 1'b0, wr_bit = 1'b0, protect_ctl = 1'b0;
   logic [1:0] drive_num = 2'h0;
   seek_kind_t seek_kind = SEEK_IMPLIED;
   logic [15:0] seek_count = 16'h0000;
   logic [RATE_W-1:0] step_rate = 8'h02;
   logic access_ready, seek_busy, seek_at_outer, wr_ready, write_protect_err, rd_bit;
   logic index_seen, write_protected, motor_on, head_dir, step, write_data, write_gate;
   logic side_select, index_in, outer_cyl_in, write_protect_in, read_data_in;
   logic [NUM_DRIVES-1:0] drive_sel;
   int cyl, error_cnt = 0, total_checks = 0, cycle_cnt = 0;
   always #5 sys_clk = ~sys_clk;
   floppy_port #(.MOTOR_SLOW_CYCLES(SLOW), .MOTOR_IDLE_CYCLES(IDLE)) floppy_port_inst (
      .sys_clk, .srst, .drive_num, .side_sel, .motor_on_mode_option, .access_req, .access_ready,
      .seek_start, .seek_kind, .seek_outward, .seek_count, .step_rate, .seek_busy, .seek_at_outer,
      .write_req, .wr_valid, .wr_ready, .wr_bit, .write_protect_err, .rd_bit, .index_seen,
      .write_protected, .drive_sel, .motor_on, .head_dir, .step, .write_data, .write_gate,
      .side_select, .index_in, .outer_cyl_in, .write_protect_in, .read_data_in);
   floppy_drive_model floppy_drive_model_inst (.sys_clk, .drive_sel, .step, .head_dir,
      .protect_ctl, .index_in, .outer_cyl_in, .write_protect_in, .read_data_in, .cyl);
   // Counts a comparison and reports a mismatch.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Every drive number and both surfaces.
   task automatic t_select();
      logic rd_prev;
      int hits = 0;
      for (int d = 0; d < NUM_DRIVES; d++) begin
         @(posedge sys_clk);
         drive_num <= d[1:0];
         side_sel <= d[0];
         repeat (2) @(posedge sys_clk);
         #1;
         check(drive_sel, 4'h1 << d);
         check(side_select, d[0]);
      end
      // The model toggles its read line every cycle, so the raw bit must follow.
      rd_prev = rd_bit;
      @(posedge sys_clk);
      #1;
      check(rd_bit, !rd_prev);
      // One revolution of the model holds exactly one index edge.
      for (int i = 0; i < 1000; i++) begin
         @(posedge sys_clk);
         #1;
         hits += index_seen;
      end
      check(hits, 1);
      $display("select done");
   endtask
   // Slow spin-up, idle turn-off, then fast settle left running.
   task automatic t_motor();
      int n = 0;
      @(posedge sys_clk);
      motor_on_mode_option <= 1'b1;
      access_req <= 1'b1;
      while (access_ready !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      check(n >= SLOW, 1'b1);
      check(motor_on, 1'b1);
      check(access_ready, 1'b1);
      access_req <= 1'b0;
      for (n = 0; motor_on !== 1'b0 && n < 1000; n++) @(posedge sys_clk);
      check(n >= IDLE && n <= IDLE + 8, 1'b1);
      motor_on_mode_option <= 1'b0;
      access_req <= 1'b1;
      for (n = 0; access_ready !== 1'b1 && n < 50; n++) @(posedge sys_clk);
      check(n <= MOTOR_FAST_CYC + 3, 1'b1);
      $display("motor done");
   endtask
   // One seek; counts step rises and checks the landing cylinder.
   task automatic t_seek(input seek_kind_t k, input logic outw, input logic [15:0] cnt,
         input int steps, input int exp_cyl, input logic dir);
      int n = 0;
      logic prev = 1'b0;
      logic dir_ok = 1'b1;
      @(posedge sys_clk);
      seek_kind <= k;
      seek_outward <= outw;
      seek_count <= cnt;
      seek_start <= 1'b1;
      @(posedge sys_clk);
      seek_start <= 1'b0;
      for (int i = 0; i < 8000; i++) begin
         @(posedge sys_clk);
         #1;
         if (step && !prev) begin
            n++;
            dir_ok &= (head_dir === dir);
         end
         prev = step;
         if (seek_busy === 1'b0) break;
      end
      check(n, steps);
      check(dir_ok, 1'b1);
      check(cyl, exp_cyl);
      check(seek_busy, 1'b0);
      check(seek_at_outer, exp_cyl == 0);
      $display("seek kind %0d done", k);
   endtask
   // Offers one bit and holds it until the buffer takes it.
   task automatic push(input logic b);
      @(posedge sys_clk);
      wr_valid <= 1'b1;
      wr_bit <= b;
      @(posedge sys_clk);
      while (wr_ready !== 1'b1) @(posedge sys_clk);
      wr_valid <= 1'b0;
   endtask
   // Fill the buffer while stalled, drain under write gate, then a protected disc.
   task automatic t_write();
      logic [1:0] got;
      push(1'b1);
      push(1'b0);
      #1;
      check(wr_ready, 1'b0); // A full buffer refuses a third bit.
      @(posedge sys_clk);
      write_req <= 1'b1;
      for (int i = 0; i < 10 && write_gate !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      got[1] = write_data;
      @(posedge sys_clk);
      #1;
      got[0] = write_data;
      check(got, 2'b10);
      repeat (4) @(posedge sys_clk);
      check(write_gate, 1'b1);
      write_req <= 1'b0;
      protect_ctl <= 1'b1;
      repeat (4) @(posedge sys_clk);
      write_req <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      check(write_gate, 1'b0);
      check(write_protect_err, 1'b1);
      check(write_protected, 1'b1);
      @(posedge sys_clk);
      write_req <= 1'b0;
      protect_ctl <= 1'b0;
      $display("write done");
   endtask
   // Cuts a hang short.
   always @(posedge sys_clk) begin
      cycle_cnt <= cycle_cnt + 1;
      if (cycle_cnt == 20000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      t_select();
      t_motor();
      t_seek(SEEK_EXPLICIT, 1'b0, 16'h0003, 3, 6, DIR_IN);
      t_seek(SEEK_IMPLIED, 1'b1, 16'h0002, 2, 4, DIR_OUT);
      t_seek(SEEK_RESTORE, 1'b0, 16'h0000, 4, 0, DIR_OUT);
      t_seek(SEEK_EXPLICIT, 1'b0, 16'h0001, 1, 1, DIR_IN);
      t_seek(SEEK_AUTO_RESTORE, 1'b0, 16'h0000, 1, 0, DIR_OUT);
      t_seek(SEEK_RESTORE, 1'b0, 16'h0000, 0, 0, DIR_OUT);
      t_write();
      end_sim();
   end
endmodule
